// ### design/gpio_ports_regs.svh
// constants for the six general-purpose parallel ports
// assumes inclusion by the package and the port module only
`ifndef GPIO_PORTS_REGS_SVH
`define GPIO_PORTS_REGS_SVH

`define PORT0_WIDTH     32
`define PORT1_WIDTH     32
`define PORT2_WIDTH     28
`define PORT3_WIDTH     16
`define PORT4_WIDTH     25
`define PORT5_WIDTH     20
`define PORT_MAX_WIDTH  32
`define PORT_COUNT      6
`define SYNC_STAGES     2
`define DIR_RESET_VALUE 32'h0000_0000
`define OUT_RESET_VALUE 32'h0000_0000

`endif

// ### design/gpio_ports_pkg.sv
// types shared by the general-purpose port block
// assumes the constants header sits beside it
`include "gpio_ports_regs.svh"

package gpio_ports_pkg;
    typedef logic [`PORT_MAX_WIDTH-1:0] port_word_t;
    typedef enum logic [0:0] {
        DIR_INPUT  = 1'h0,
        DIR_OUTPUT = 1'h1
    } pin_dir_t;
endpackage

// ### design/gpio_ports.sv
// six general-purpose parallel ports with per-pin direction and level
// assumes software writes arrive as per-port word strobes on I_MCLK,
// and that pads resolve the three pin signals outside this module;
// pins above a port's width read zero and are never driven
// reset is synchronous; every pin is released while it is held
//
// Operation
// - separate direction and output bit per pin
// - pin inputs synchronised before software reads them
// - output direction drives the held output level
// - input direction releases pin to high impedance
// - open-drain by toggling direction only
// - ports zero and one have thirty-two pins
// - port two 28 pins, port three 16
// - port four 25 pins, port five 20
// - all ports share the peripheral bus clock
// - all directions reset to input
// - each pin direction programmable independently
`timescale 1ns/1ps
`include "gpio_ports_regs.svh"

module gpio_ports #(
    parameter int PORTS    = `PORT_COUNT,
    // pins per port; a width above the word size is not supported
    parameter int P0_WIDTH = `PORT0_WIDTH,
    parameter int P1_WIDTH = `PORT1_WIDTH,
    parameter int P2_WIDTH = `PORT2_WIDTH,
    parameter int P3_WIDTH = `PORT3_WIDTH,
    parameter int P4_WIDTH = `PORT4_WIDTH,
    parameter int P5_WIDTH = `PORT5_WIDTH
) (
    // clock and reset
    input  wire logic                     I_MCLK,
    input  wire logic                     I_RST_N,
    // software write of direction words, one strobe per port
    input  wire logic [PORTS-1:0]         I_DIR_WE,
    input  wire gpio_ports_pkg::port_word_t I_DIR_WDATA,
    // bit mask limits a direction write to chosen pins
    input  wire gpio_ports_pkg::port_word_t I_DIR_WMASK,
    // software write of output level words
    input  wire logic [PORTS-1:0]         I_OUT_WE,
    input  wire gpio_ports_pkg::port_word_t I_OUT_WDATA,
    input  wire gpio_ports_pkg::port_word_t I_OUT_WMASK,
    // pad inputs, one word per port
    input  wire gpio_ports_pkg::port_word_t I_PIN_IN [PORTS],
    // pad outputs and enables (enable low while driving)
    output logic [`PORT_MAX_WIDTH-1:0]    O_PIN_OUT   [PORTS],
    output logic [`PORT_MAX_WIDTH-1:0]    O_PIN_OE_N  [PORTS],
    // readback of registers and synchronised inputs
    output logic [`PORT_MAX_WIDTH-1:0]    O_DIR_RDATA [PORTS],
    output logic [`PORT_MAX_WIDTH-1:0]    O_OUT_RDATA [PORTS],
    output logic [`PORT_MAX_WIDTH-1:0]    O_IN_RDATA  [PORTS]
);
    import gpio_ports_pkg::*;

    // direction and level writes may strobe in the same cycle; both
    // land on one edge, so an open-drain user never sees a pin that
    // drives a stale level for a cycle
    
    // number of pins that exist on each port; an index past the last
    // port falls back to the first port's width
    function automatic int width_of(input int idx);
        int w;
        if (idx == 1) begin
            w = P1_WIDTH;
        end else if (idx == 2) begin
            w = P2_WIDTH;
        end else if (idx == 3) begin
            w = P3_WIDTH;
        end else if (idx == 4) begin
            w = P4_WIDTH;
        end else if (idx == 5) begin
            w = P5_WIDTH;
        end else begin
            w = P0_WIDTH;
        end
        width_of = w;
    endfunction

    // one bit per existing pin; missing pins stay zero and undriven,
    // whatever software writes into them
    function automatic port_word_t width_mask(input int idx);
        int w;
        w = width_of(idx);
        width_mask = (w >= `PORT_MAX_WIDTH) ? '1
                   : port_word_t'((33'h1 << w) - 33'h1);
    endfunction

    genvar p;
    genvar b;

    // each port is its own slice; ports share nothing but the bus
    // clock, the reset and the write buses, so one port's write never moves another
    generate
        for (p = 0; p < PORTS; p++) begin : g_port
            localparam port_word_t PMASK = width_mask(p);
            port_word_t dir_reg;
            port_word_t dir_next;
            port_word_t out_reg;
            port_word_t out_next;
            port_word_t sync1_reg;
            // decoded pad controls, one driver per pin
            wire port_word_t drive_next;
            wire port_word_t level_next;

            // masked merge leaves the other pins of the port untouched
            always_comb begin
                if (I_DIR_WE[p]) begin
                    dir_next = ((dir_reg & ~I_DIR_WMASK)
                             | (I_DIR_WDATA & I_DIR_WMASK)) & PMASK;
                end else begin
                    dir_next = dir_reg;
                end
            end

            // open-drain use parks a value here and only flips direction
            always_comb begin
                if (I_OUT_WE[p]) begin
                    out_next = ((out_reg & ~I_OUT_WMASK)
                             | (I_OUT_WDATA & I_OUT_WMASK)) & PMASK;
                end else begin
                    out_next = out_reg;
                end
            end

            // per-pin decode of the next direction word; a missing pin
            // decodes as input whatever the word holds
            for (b = 0; b < `PORT_MAX_WIDTH; b++) begin : g_pin
                pin_dir_t pin_dir;
                assign pin_dir = PMASK[b] ? pin_dir_t'(dir_next[b])
                                          : DIR_INPUT;
                assign drive_next[b] = (pin_dir == DIR_OUTPUT);
                assign level_next[b] = out_next[b] & PMASK[b];
            end

            // all ports run on the shared bus clock, so no crossing is needed
            // between them; every register of the port is clocked by I_MCLK
            always_ff @(posedge I_MCLK) begin
                if (!I_RST_N) begin
                    dir_reg <= port_word_t'(`DIR_RESET_VALUE);
                end else begin
                    dir_reg <= dir_next;
                end
            end

            // the level survives direction changes untouched
            always_ff @(posedge I_MCLK) begin
                if (!I_RST_N) begin
                    out_reg <= port_word_t'(`OUT_RESET_VALUE);
                end else begin
                    out_reg <= out_next;
                end
            end

            // first synchroniser stage; nothing else may read it
            always_ff @(posedge I_MCLK) begin
                if (!I_RST_N) begin
                    sync1_reg <= '0;
                end else begin
                    sync1_reg <= I_PIN_IN[p] & PMASK;
                end
            end

            // the readback flop is the second stage, so a pin change
            // shows to software one edge after the first stage samples it
            always_ff @(posedge I_MCLK) begin
                if (!I_RST_N) begin
                    O_IN_RDATA[p] <= '0;
                end else begin
                    O_IN_RDATA[p] <= sync1_reg;
                end
            end

            // pads follow the next values, so a pin moves on the same
            // edge as its register and no extra cycle of lag appears
            always_ff @(posedge I_MCLK) begin
                if (!I_RST_N) begin
                    O_PIN_OUT[p] <= '0;
                end else begin
                    O_PIN_OUT[p] <= level_next;
                end
            end

            // direction alone switches a pin between driven and
            // released; reset releases every pin to avoid bus fights
            always_ff @(posedge I_MCLK) begin
                if (!I_RST_N) begin
                    O_PIN_OE_N[p] <= '1;
                end else begin
                    O_PIN_OE_N[p] <= ~drive_next;
                end
            end

            // readbacks mirror the registers as they stand after the edge
            always_ff @(posedge I_MCLK) begin
                if (!I_RST_N) begin
                    O_DIR_RDATA[p] <= '0;
                end else begin
                    O_DIR_RDATA[p] <= dir_next;
                end
            end

            always_ff @(posedge I_MCLK) begin
                if (!I_RST_N) begin
                    O_OUT_RDATA[p] <= '0;
                end else begin
                    O_OUT_RDATA[p] <= out_next;
                end
            end
        end
    endgenerate

endmodule

// ### sim/gpio_ports_checker.sv
// assertions on the six-port parallel block
// bound to gpio_ports, sees its ports only
`timescale 1ns/1ps
module gpio_ports_checker #(parameter int PORTS = 6) (
    input logic                       I_MCLK, I_RST_N,
    input logic [PORTS-1:0]           I_DIR_WE, I_OUT_WE,
    input gpio_ports_pkg::port_word_t I_DIR_WDATA, I_DIR_WMASK,
    input gpio_ports_pkg::port_word_t I_OUT_WDATA, I_OUT_WMASK,
    input gpio_ports_pkg::port_word_t I_PIN_IN [PORTS],
    input logic [31:0]                O_PIN_OUT [PORTS], O_PIN_OE_N [PORTS],
    input logic [31:0]                O_DIR_RDATA [PORTS], O_OUT_RDATA [PORTS],
    input logic [31:0]                O_IN_RDATA [PORTS]
);
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (!I_RST_N);
    chk_oe_dir: assert property (
        O_PIN_OE_N[0] == ~O_DIR_RDATA[0])
        else $error("enable vs direction");
    chk_drive_level: assert property (
        ((O_PIN_OUT[0] ^ O_OUT_RDATA[0]) & ~O_PIN_OE_N[0]) == 0)
        else $error("driven level");
    chk_dir_write: assert property (
        I_DIR_WE[0] |=> O_DIR_RDATA[0] ==
            (($past(I_DIR_WDATA) & $past(I_DIR_WMASK))
            | ($past(O_DIR_RDATA[0]) & ~$past(I_DIR_WMASK))))
        else $error("direction write");
    chk_out_write: assert property (
        I_OUT_WE[0] |=> O_OUT_RDATA[0] ==
            (($past(I_OUT_WDATA) & $past(I_OUT_WMASK))
            | ($past(O_OUT_RDATA[0]) & ~$past(I_OUT_WMASK))))
        else $error("level write");
    chk_out_hold: assert property (
        !I_OUT_WE[0] |=> $stable(O_OUT_RDATA[0]))
        else $error("level moved");
    chk_sync_two: assert property (
        $past(I_RST_N, 2) && $past(I_RST_N)
            |-> O_IN_RDATA[0] == $past(I_PIN_IN[0], 2))
        else $error("input delay");
    chk_narrow_ports: assert property (
        &{O_PIN_OE_N[2][31:28], O_PIN_OE_N[3][31:16],
          O_PIN_OE_N[4][31:25], O_PIN_OE_N[5][31:20]})
        else $error("missing pin driven");
    chk_reset_input: assert property (
        disable iff (1'b0) !I_RST_N |=> O_PIN_OE_N[0] == '1)
        else $error("reset drives");
    cover property ($rose(O_PIN_OE_N[0][0]));
    cover property (I_DIR_WE[0]);
    cover property (I_OUT_WE[0]);
    cover property ($changed(O_IN_RDATA[0]));
endmodule

// ### sim/gpio_board.sv
// board side of the pads: pull-ups on every pin
// expects pad enable low while the block drives
`timescale 1ns/1ps
module gpio_board (
    input  logic [31:0] i_out  [6],
    input  logic [31:0] i_oe_n [6],
    output logic [31:0] o_pin  [6]
);
    // a released pin rises through its pull-up
    always_comb begin
        for (int p = 0; p < 6; p++) begin
            o_pin[p] = (~i_oe_n[p] & i_out[p]) | i_oe_n[p];
        end
    end
endmodule

// ### sim/general_purpose_io_ports_tb.sv
// bench for the six parallel ports, one task a scenario
// drives at the falling edge; gpio_board resolves the pads
`timescale 1ns/1ps
module general_purpose_io_ports_tb;
    logic        clk = 0;
    logic        rst_n = 0;
    logic [5:0]  dir_we = 0;
    logic [5:0]  out_we = 0;
    logic [31:0] wd = 0;
    logic [31:0] wm = 0;
    logic [31:0] pin [6];
    logic [31:0] po  [6];
    logic [31:0] oe  [6];
    logic [31:0] dr  [6];
    logic [31:0] orr [6];
    logic [31:0] ir  [6];
    // pins that exist on each port
    logic [31:0] live [6] = '{'1, '1, 32'h0fff_ffff, 32'h0000_ffff,
                              32'h01ff_ffff, 32'h000f_ffff};
    int          error_cnt = 0;
    int          cmp_count = 0;

    always #4 clk = ~clk;

    gpio_ports dut (
        .I_MCLK      (clk),
        .I_RST_N     (rst_n),
        .I_DIR_WE    (dir_we),
        .I_DIR_WDATA (wd),
        .I_DIR_WMASK (wm),
        .I_OUT_WE    (out_we),
        .I_OUT_WDATA (wd),
        .I_OUT_WMASK (wm),
        .I_PIN_IN    (pin),
        .O_PIN_OUT   (po),
        .O_PIN_OE_N  (oe),
        .O_DIR_RDATA (dr),
        .O_OUT_RDATA (orr),
        .O_IN_RDATA  (ir)
    );
    gpio_board board (.i_out(po), .i_oe_n(oe), .o_pin(pin));

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one strobe held across exactly one rising edge
    task automatic wr(input logic d, input logic [5:0] we,
                      input logic [31:0] v, input logic [31:0] m);
        @(negedge clk);
        wd = v;
        wm = m;
        if (d) begin
            dir_we = we;
        end else begin
            out_we = we;
        end
        @(negedge clk);
        dir_we = 0;
        out_we = 0;
    endtask

    task automatic t_dir;
        wr(0, 6'h01, 32'ha5a5_5a5a, '1);
        wr(1, 6'h01, '1, 32'h0000_ffff);
        wr(1, 6'h01, 32'h0, 32'hffff_0000);
        cmp(dr[0], 32'h0000_ffff);
        cmp(orr[0], 32'ha5a5_5a5a);
        cmp(pin[0], 32'hffff_5a5a);
        repeat (3) @(negedge clk);
        cmp(ir[0], 32'hffff_5a5a);
        $display("direction test done");
    endtask

    task automatic t_open;
        wr(0, 6'h01, 32'h0, '1);
        cmp(orr[0], 32'h0);
        wr(1, 6'h01, '1, '1);
        cmp(pin[0], 32'h0);
        cmp(orr[0], 32'h0);
        wr(1, 6'h01, 32'h0, '1);
        cmp(pin[0], '1);
        @(negedge clk);
        cmp(ir[0], 32'h0);
        @(negedge clk);
        cmp(ir[0], '1);
        $display("open drain test done");
    endtask

    task automatic t_width;
        for (int p = 0; p < 6; p++) begin
            cmp(ir[p], live[p]);
        end
        wr(1, 6'h3f, '1, '1);
        for (int p = 0; p < 6; p++) begin
            cmp(dr[p], live[p]);
            cmp(pin[p], ~live[p]);
        end
        $display("width test done");
    endtask

    // reset in mid-run with every existing pin driven
    task automatic t_reset;
        @(negedge clk);
        rst_n = 0;
        repeat (2) @(negedge clk);
        for (int p = 0; p < 6; p++) begin
            cmp(oe[p], '1);
            cmp(dr[p], 32'h0);
        end
        rst_n = 1;
        @(negedge clk);
        for (int p = 0; p < 6; p++) begin
            cmp(pin[p], '1);
        end
        $display("reset test done");
    endtask

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1;
        for (int p = 0; p < 6; p++) begin
            cmp(oe[p], '1);
        end
        t_dir;
        t_open;
        t_width;
        t_reset;
        print_verdict;
    end
endmodule
bind gpio_ports gpio_ports_checker #(.PORTS(PORTS)) chk (.I_MCLK, .I_RST_N,
    .I_DIR_WE, .I_OUT_WE, .I_DIR_WDATA, .I_DIR_WMASK, .I_OUT_WDATA,
    .I_OUT_WMASK, .I_PIN_IN, .O_PIN_OUT, .O_PIN_OE_N, .O_DIR_RDATA,
    .O_OUT_RDATA, .O_IN_RDATA);
